// ### logic/servo_io_regs.svh
// Contract
// (RULE1) Message is 8 bytes: control byte, block, command code, response code, data.
// (RULE2) A move starts only on start-move rise with code 0x01, 0x11, 0x12, 0x1E, 0x1F.
// (RULE3) A started move runs to completion even if start-move drops.
// (RULE4) Start-block rise begins stored blocks from the block number in byte 1.
// (RULE5) Start-block falling during block execution stops block execution.
// (RULE6) Absolute/incremental bit is sampled at the start-move rise.
// (RULE7) Incremental target is current position plus data; absolute target is data.
// (RULE8) Direction bit selects continuous rotation and matters only for code 0x11.
// (RULE9) Smooth-stop rise decelerates with the configured profile, regardless of data valid.
// (RULE10) Hard-stop rise stops at maximum deceleration, regardless of data valid.
// (RULE11) Codes and data latch only with data valid; enable and stops always.
// (RULE12) Dropping data valid while an error is flagged clears the command error.
// (RULE13) Enable is a level; servo is on only while it is held at 1.
// (RULE14) Releasing external stop while enable is 1 turns the servo on at once.
// (RULE15) Axis instance must be 1; any other value raises a command error.
// (RULE16) Command codes decode into target, speed, rates, return type, alarm clear, switch.
// (RULE17) The master must not send reserved command codes.
// (RULE18) Response data follows the response code; reserved codes read zero.
// (RULE19) Code 0x1F takes its target from the stored end position parameter.
// (RULE20) New data and a start-move rise in one message start with that data.
// (RULE21) The master supplies only positive speeds and rates.
// (RULE22) Latched rates apply to positioning, continuous operation and origin returns.
// (RULE23) Code 0x11 runs at the latched speed in the direction bit's sense; the code takes o_cont_speed from the 0x11 data, not o_target_speed.
// (RULE24) After a valid message the data is checked, valid echoed, error flagged on failure.
// (RULE25) A reserved command code with data valid flags an error and moves nothing.
`ifndef SERVO_IO_REGS_SVH
`define SERVO_IO_REGS_SVH

`define OFS_CMD_LO 8'h00
`define OFS_CMD_HI 8'h04
`define OFS_RSP_LO 8'h08
`define OFS_RSP_HI 8'h0c

`define BIT_ENABLE 7
`define BIT_VALID 6
`define BIT_HARD 5
`define BIT_SMOOTH 4
`define BIT_DIR 3
`define BIT_INCR 2
`define BIT_BLOCK 1
`define BIT_MOVE 0

`define AXIS_ONE 3'h1
`define CODE_NOP 5'h00
`define CODE_POS 5'h01
`define CODE_SPEED 5'h02
`define CODE_ACCEL 5'h03
`define CODE_DECEL 5'h04
`define CODE_CONT 5'h11
`define CODE_ORIGIN 5'h12
`define CODE_ALM_CLR 5'h1e
`define CODE_SWITCH 5'h1f

`define RSP_CUR_POS 5'h01
`define RSP_REF_POS 5'h02
`define RSP_CUR_SPD 5'h03
`define RSP_TORQUE 5'h05
`define RSP_ALARM 5'h1e

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO32 32'h0000_0000
`define ZERO8 8'h00

`endif

// ### logic/servo_io_pkg.sv
package servo_io_pkg;

    typedef enum logic [0:0] {TRAJ_IDLE, TRAJ_MOVING} traj_e;

    typedef enum logic [2:0] {MOVE_POSITION, MOVE_CONTINUOUS, MOVE_ORIGIN, MOVE_ALARM_CLEAR,
                              MOVE_SWITCH} move_kind_e;

    typedef struct packed {
        traj_e traj;
        logic [7:0] ctl;
        logic [7:0] blk_num;
        logic [4:0] cmd_code;
        logic [4:0] rsp_code;
        logic [31:0] cmd_data;
        logic [31:0] lo_image;
        logic [31:0] hi_stage;
        logic rsp_valid;
        logic cmd_err;
        logic servo_on;
        logic incremental;
        logic direction;
        logic [31:0] target;
        logic [31:0] speed;
        logic [31:0] cont_speed;
        logic [31:0] accel;
        logic [31:0] decel;
        logic [7:0] ret_type;
        logic move_start;
        move_kind_e move_kind;
        logic block_start;
        logic block_stop;
        logic smooth_stop;
        logic hard_stop;
        logic aw_v;
        logic [7:0] aw_addr;
        logic w_v;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;

endpackage

// ### logic/servo_io_command_decoder.sv
`include "servo_io_regs.svh"

module servo_io_command_decoder
    import servo_io_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // AXI4-Lite write address and data.
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response.
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read.
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Motion engine status.
    input wire logic [31:0] i_cur_position,
    input wire logic [31:0] i_ref_position,
    input wire logic [31:0] i_cur_speed,
    input wire logic [31:0] i_torque,
    input wire logic [31:0] i_alarm_code,
    input wire logic [31:0] i_stored_end_position_param,
    input wire logic i_move_done,
    input wire logic i_block_busy,
    input wire logic [7:0] i_exec_block,
    input wire logic i_ext_stop,
    input wire logic i_alarm,
    input wire logic i_servo_ready,
    // Motion engine commands.
    output logic o_servo_on,
    output logic o_move_start,
    output move_kind_e o_move_kind,
    output logic [31:0] o_target_position,
    output logic [31:0] o_target_speed,
    output logic [31:0] o_cont_speed,
    output logic o_direction,
    output logic [31:0] o_accel,
    output logic [31:0] o_decel,
    output logic [7:0] o_return_type,
    output logic o_block_start,
    output logic [7:0] o_block_number,
    output logic o_block_stop,
    output logic o_smooth_stop,
    output logic o_hard_stop,
    output logic o_traj_busy
);

    state_s q;
    state_s d;

    logic do_write;
    logic commit;
    logic [31:0] merged;
    logic [7:0] nb0;
    logic code_ok;
    logic axis_ok;
    logic [4:0] eff_code;
    logic [31:0] eff_data;
    logic move_rise;
    logic [31:0] rsp_lo;
    logic [31:0] rsp_hi;

    assign do_write = q.aw_v && q.w_v && !q.bvalid;
    assign commit = do_write && q.aw_addr == `OFS_CMD_LO;

    always_comb
    begin
        merged = q.lo_image;
        for (int i = 0; i < 4; i++)
        begin
            if (q.wstrb[i])
            begin
                merged[8*i +: 8] = q.wdata[8*i +: 8];
            end
        end
    end

    assign nb0 = merged[7:0];
    assign axis_ok = merged[23:21] == `AXIS_ONE && merged[31:29] == `AXIS_ONE; // RULE15

    // Reserved codes are refused here so that they never reach the motion engine.
    always_comb
    begin
        case (merged[20:16]) // RULE16 RULE25
            `CODE_NOP, `CODE_POS, `CODE_SPEED, `CODE_ACCEL, `CODE_DECEL,
            `CODE_CONT, `CODE_ORIGIN, `CODE_ALM_CLR, `CODE_SWITCH: code_ok = 1'b1;
            default: code_ok = 1'b0;
        endcase
    end

    // Fresh data in the same message is used by a start in that message.
    assign eff_code = nb0[`BIT_VALID] ? merged[20:16] : q.cmd_code; // RULE20
    assign eff_data = nb0[`BIT_VALID] ? q.hi_stage : q.cmd_data; // RULE20
    assign move_rise = commit && nb0[`BIT_MOVE] && !q.ctl[`BIT_MOVE]; // RULE2

    always_comb
    begin
        rsp_lo = {`AXIS_ONE, q.rsp_code, q.cmd_err, 6'h00, i_servo_ready, i_exec_block,
                  q.servo_on, q.rsp_valid, 1'b0, i_ext_stop, i_alarm, 1'b0, i_block_busy,
                  q.traj == TRAJ_MOVING};
        case (q.rsp_code) // RULE18
            `RSP_CUR_POS: rsp_hi = i_cur_position;
            `RSP_REF_POS: rsp_hi = i_ref_position;
            `RSP_CUR_SPD: rsp_hi = i_cur_speed;
            `RSP_TORQUE: rsp_hi = i_torque;
            `RSP_ALARM: rsp_hi = i_alarm_code;
            default: rsp_hi = `ZERO32;
        endcase
    end

    always_comb
    begin
        d = q;
        d.move_start = 1'b0;
        d.block_start = 1'b0;
        d.block_stop = 1'b0;
        d.smooth_stop = 1'b0;
        d.hard_stop = 1'b0;

        // AXI4-Lite slave.
        if (i_awvalid && !q.aw_v)
        begin
            d.aw_v = 1'b1;
            d.aw_addr = i_awaddr;
        end
        if (i_wvalid && !q.w_v)
        begin
            d.w_v = 1'b1;
            d.wdata = i_wdata;
            d.wstrb = i_wstrb;
        end
        if (q.bvalid && i_bready)
        begin
            d.bvalid = 1'b0;
        end
        if (do_write)
        begin
            d.aw_v = 1'b0;
            d.w_v = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `RESP_OKAY;
            if (q.aw_addr == `OFS_CMD_HI)
            begin
                for (int i = 0; i < 4; i++)
                begin
                    if (q.wstrb[i])
                    begin
                        d.hi_stage[8*i +: 8] = q.wdata[8*i +: 8];
                    end
                end
            end
            else if (q.aw_addr == `OFS_CMD_LO)
            begin
                d.lo_image = merged;
            end
            else
            begin
                d.bresp = `RESP_SLVERR;
            end
        end
        if (q.rvalid && i_rready)
        begin
            d.rvalid = 1'b0;
        end
        if (i_arvalid && !q.rvalid)
        begin
            d.rvalid = 1'b1;
            d.rresp = `RESP_OKAY;
            case (i_araddr)
                `OFS_CMD_LO: d.rdata = q.lo_image;
                `OFS_CMD_HI: d.rdata = q.hi_stage;
                `OFS_RSP_LO: d.rdata = rsp_lo;
                `OFS_RSP_HI: d.rdata = rsp_hi;
                default:
                begin
                    d.rdata = `ZERO32;
                    d.rresp = `RESP_SLVERR;
                end
            endcase
        end

        // Command message, taken as a whole when the low word is written.
        if (commit)
        begin // RULE1
            d.ctl = nb0; // RULE11
            d.blk_num = merged[15:8];
            d.smooth_stop = nb0[`BIT_SMOOTH] && !q.ctl[`BIT_SMOOTH]; // RULE9
            d.hard_stop = nb0[`BIT_HARD] && !q.ctl[`BIT_HARD]; // RULE10
            if (nb0[`BIT_VALID])
            begin
                d.cmd_code = merged[20:16]; // RULE11
                d.rsp_code = merged[28:24]; // RULE11
                d.cmd_data = q.hi_stage; // RULE11
                d.rsp_valid = 1'b1; // RULE24
                d.cmd_err = !(axis_ok && code_ok); // RULE24 RULE15 RULE25
                case (merged[20:16]) // RULE16 RULE22
                    `CODE_SPEED: d.speed = q.hi_stage;
                    `CODE_ACCEL: d.accel = q.hi_stage;
                    `CODE_DECEL: d.decel = q.hi_stage;
                    default:
                    begin
                    end
                endcase
            end
            else
            begin
                d.rsp_valid = 1'b0;
                d.cmd_err = 1'b0; // RULE12
            end
            if (nb0[`BIT_BLOCK] && !q.ctl[`BIT_BLOCK])
            begin
                d.block_start = 1'b1; // RULE4
            end
            if (!nb0[`BIT_BLOCK] && q.ctl[`BIT_BLOCK] && i_block_busy)
            begin
                d.block_stop = 1'b1; // RULE5
            end
            // A start is ignored while the servo is off or the message is in error.
            if (move_rise && q.servo_on && !d.cmd_err)
            begin
                d.incremental = nb0[`BIT_INCR]; // RULE6
                d.move_start = 1'b1; // RULE2
                case (eff_code) // RULE2
                    `CODE_POS:
                    begin
                        d.move_kind = MOVE_POSITION;
                        d.target = nb0[`BIT_INCR] ? i_cur_position + eff_data : eff_data; // RULE7
                    end
                    `CODE_CONT:
                    begin
                        d.move_kind = MOVE_CONTINUOUS; // RULE23
                        d.cont_speed = eff_data; // RULE23
                        d.direction = nb0[`BIT_DIR]; // RULE8
                    end
                    `CODE_ORIGIN:
                    begin
                        d.move_kind = MOVE_ORIGIN;
                        d.ret_type = eff_data[7:0]; // RULE16
                    end
                    `CODE_ALM_CLR:
                    begin
                        d.move_kind = MOVE_ALARM_CLEAR;
                        d.move_start = eff_data[0]; // RULE16
                    end
                    `CODE_SWITCH:
                    begin
                        d.move_kind = MOVE_SWITCH;
                        d.target = i_stored_end_position_param; // RULE19
                    end
                    default: d.move_start = 1'b0; // RULE2
                endcase
            end
        end

        // Travel ends only when the engine reports it, never when start-move drops.
        case (q.traj) // RULE3
            TRAJ_IDLE:
            begin
                if (q.move_start && q.move_kind != MOVE_ALARM_CLEAR)
                begin
                    d.traj = TRAJ_MOVING;
                end
            end
            TRAJ_MOVING:
            begin
                if (i_move_done)
                begin
                    d.traj = TRAJ_IDLE;
                end
            end
            default: d.traj = TRAJ_IDLE;
        endcase

        d.servo_on = d.ctl[`BIT_ENABLE] && !i_ext_stop; // RULE13 RULE14
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_awready = !q.aw_v;
    assign o_wready = !q.w_v;
    assign o_bvalid = q.bvalid;
    assign o_bresp = q.bresp;
    assign o_arready = !q.rvalid;
    assign o_rvalid = q.rvalid;
    assign o_rdata = q.rdata;
    assign o_rresp = q.rresp;
    assign o_servo_on = q.servo_on;
    assign o_move_start = q.move_start;
    assign o_move_kind = q.move_kind;
    assign o_target_position = q.target;
    assign o_target_speed = q.speed;
    assign o_cont_speed = q.cont_speed;
    assign o_direction = q.direction;
    assign o_accel = q.accel;
    assign o_decel = q.decel;
    assign o_return_type = q.ret_type;
    assign o_block_start = q.block_start;
    assign o_block_number = q.blk_num;
    assign o_block_stop = q.block_stop;
    assign o_smooth_stop = q.smooth_stop;
    assign o_hard_stop = q.hard_stop;
    assign o_traj_busy = q.traj == TRAJ_MOVING;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    a_move_needs_rise: assert property (o_move_start |-> $past(move_rise) && $past(q.servo_on)) // RULE2
        else $error("move started without a start-move rise");
    a_travel_holds: assert property (q.traj == TRAJ_MOVING && !i_move_done |=> q.traj == TRAJ_MOVING) // RULE3
        else $error("travel ended before the engine reported done");
    a_block_start: assert property (commit && nb0[`BIT_BLOCK] && !q.ctl[`BIT_BLOCK]
        |=> o_block_start && o_block_number == $past(merged[15:8])) // RULE4
        else $error("block start missing or wrong block number");
    a_incr_target: assert property (move_rise && q.servo_on && !d.cmd_err && eff_code == `CODE_POS
        && nb0[`BIT_INCR] |=> o_target_position == $past(i_cur_position) + $past(eff_data)) // RULE7
        else $error("incremental target is not position plus data");
    a_smooth_edge: assert property (o_smooth_stop |-> $past(commit) && !$past(q.ctl[`BIT_SMOOTH])) // RULE9
        else $error("smooth stop without a rising edge");
    a_valid_gate: assert property (commit && !nb0[`BIT_VALID]
        |=> q.cmd_code == $past(q.cmd_code) && q.cmd_data == $past(q.cmd_data)) // RULE11
        else $error("codes changed without data valid");
    a_err_clear: assert property (commit && !nb0[`BIT_VALID] |=> !q.cmd_err) // RULE12
        else $error("command error not cleared when valid dropped");
    a_servo_level: assert property (o_servo_on |-> q.ctl[`BIT_ENABLE] && !$past(i_ext_stop)) // RULE13
        else $error("servo on without enable");
    a_stop_release: assert property (q.ctl[`BIT_ENABLE] && !i_ext_stop && !commit |=> o_servo_on) // RULE14
        else $error("servo not on after external stop release");
    a_axis_error: assert property (commit && nb0[`BIT_VALID] && !axis_ok |=> q.cmd_err && q.rsp_valid) // RULE15
        else $error("bad axis instance not flagged");

    c_position_move: cover property (o_move_start && o_move_kind == MOVE_POSITION ##[1:50] i_move_done);
    c_block_stop: cover property (o_block_start ##[1:50] o_block_stop);
    c_hard_stop: cover property (q.traj == TRAJ_MOVING && o_hard_stop);

endmodule

// ### testbench/motion_engine_model.sv
module motion_engine_model
#(
    parameter int DONE_CYCLES = 30
)
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // Commands from the decoder.
    input wire logic i_move_start,
    input wire logic i_block_start,
    input wire logic i_block_stop,
    input wire logic i_smooth_stop,
    input wire logic i_hard_stop,
    // Status back to the decoder.
    output logic o_move_done,
    output logic o_block_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    int count_q;

    // Travel lasts a fixed time unless a stop cuts it short, so done never follows start at once.
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            count_q <= 0;
            o_move_done <= 1'b0;
            o_block_busy <= 1'b0;
        end
        else
        begin
            o_move_done <= (count_q == 1) || (count_q != 0 && (i_smooth_stop || i_hard_stop));
            if (i_move_start)
                count_q <= DONE_CYCLES;
            else if (count_q != 0)
                count_q <= (i_smooth_stop || i_hard_stop) ? 0 : count_q - 1;
            if (i_block_start)
                o_block_busy <= 1'b1;
            else if (i_block_stop)
                o_block_busy <= 1'b0;
        end
    end
endmodule

// ### testbench/servo_io_command_decoder_tb_top.sv
`include "servo_io_regs.svh"

module servo_io_command_decoder_tb_top
    import servo_io_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] CUR = 32'h0000_00c8;
    localparam logic [31:0] REFP = 32'h0000_00d2;
    localparam logic [31:0] SPD = 32'h0000_0040;
    localparam logic [31:0] TRQ = 32'h0000_001e;
    localparam logic [31:0] ALM = 32'h0000_000a;
    localparam logic [31:0] ENDP = 32'h0000_07d0;
    logic i_clk = 0, i_reset = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    logic [7:0] i_awaddr = 0, i_araddr = 0;
    logic [31:0] i_wdata = 0;
    logic [3:0] i_wstrb = 0;
    logic i_ext_stop = 0, i_move_done, i_block_busy;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_servo_on, o_move_start, o_direction;
    logic o_block_start, o_block_stop, o_smooth_stop, o_hard_stop, o_traj_busy;
    logic [1:0] o_bresp, o_rresp, r;
    logic [31:0] o_rdata, o_target_position, o_target_speed, o_cont_speed, o_accel, o_decel, d;
    logic [7:0] o_return_type, o_block_number;
    move_kind_e o_move_kind, last_kind;
    int num_errors = 0, compares = 0, n_mv = 0, n_sm = 0, n_hd = 0, n_bs = 0, n_be = 0, base;
    logic [4:0] codes [5] = '{5'h01, 5'h11, 5'h12, 5'h1e, 5'h1f};
    logic [4:0] rcodes [6] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h1e, 5'h04};
    logic [31:0] rexp [6] = '{CUR, REFP, SPD, TRQ, ALM, 32'h0};

    always #50 i_clk = ~i_clk;

    servo_io_command_decoder servo_io_command_decoder_i (.i_clk(i_clk), .i_reset(i_reset),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .i_cur_position(CUR), .i_ref_position(REFP), .i_cur_speed(SPD), .i_torque(TRQ), .i_alarm_code(ALM),
        .i_stored_end_position_param(ENDP), .i_move_done(i_move_done), .i_block_busy(i_block_busy),
        .i_exec_block(8'h00), .i_ext_stop(i_ext_stop), .i_alarm(1'b0), .i_servo_ready(1'b0),
        .o_servo_on(o_servo_on), .o_move_start(o_move_start), .o_move_kind(o_move_kind),
        .o_target_position(o_target_position), .o_target_speed(o_target_speed), .o_cont_speed(o_cont_speed),
        .o_direction(o_direction), .o_accel(o_accel), .o_decel(o_decel), .o_return_type(o_return_type),
        .o_block_start(o_block_start), .o_block_number(o_block_number), .o_block_stop(o_block_stop),
        .o_smooth_stop(o_smooth_stop), .o_hard_stop(o_hard_stop), .o_traj_busy(o_traj_busy));

    motion_engine_model motion_engine_model_i (.i_clk(i_clk), .i_reset(i_reset), .i_move_start(o_move_start),
        .i_block_start(o_block_start), .i_block_stop(o_block_stop), .i_smooth_stop(o_smooth_stop),
        .i_hard_stop(o_hard_stop), .o_move_done(i_move_done), .o_block_busy(i_block_busy));

    // Pulses stand one cycle only, so they are counted at every edge.
    always @(posedge i_clk)
    begin
        if (o_move_start === 1'b1)
        begin
            n_mv++;
            last_kind = o_move_kind;
        end
        if (o_smooth_stop === 1'b1) n_sm++;
        if (o_hard_stop === 1'b1) n_hd++;
        if (o_block_start === 1'b1) n_bs++;
        if (o_block_stop === 1'b1) n_be++;
    end

    task automatic test_done();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Wide enough for the paired fields that some checks concatenate.
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang(input int n);
        if (n >= 100)
        begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, 0, 1);
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp,
                      input logic [3:0] s = 4'hf);
        int n;
        n = 0;
        @(posedge i_clk);
        i_awvalid <= 1;
        i_awaddr <= a;
        i_wvalid <= 1;
        i_wdata <= v;
        i_wstrb <= s;
        i_bready <= 1;
        do
        begin
            @(posedge i_clk);
            n++;
            if (i_awvalid && o_awready === 1'b1) i_awvalid <= 0;
            if (i_wvalid && o_wready === 1'b1) i_wvalid <= 0;
        end
        while (o_bvalid !== 1'b1 && n < 100);
        resp = o_bresp;
        i_bready <= 0;
        hang(n);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge i_clk);
        i_arvalid <= 1;
        i_araddr <= a;
        i_rready <= 1;
        do
        begin
            @(posedge i_clk);
            n++;
            if (i_arvalid && o_arready === 1'b1) i_arvalid <= 0;
        end
        while (o_rvalid !== 1'b1 && n < 100);
        v = o_rdata;
        resp = o_rresp;
        i_rready <= 0;
        hang(n);
    endtask

    // Data word first, then the low word that commits the whole message.
    task automatic msg(input logic [7:0] ctl, input logic [4:0] code, input logic [31:0] v = 0,
                       input logic [2:0] axis = 3'h1, input logic [7:0] blk = 0, input logic [4:0] rc = 5'h01);
        wr(`OFS_CMD_HI, v, r);
        wr(`OFS_CMD_LO, {axis, rc, axis, code, blk, ctl}, r);
        repeat (2) @(posedge i_clk);
    endtask

    task automatic wait_idle();
        int n;
        for (n = 0; n < 100 && o_traj_busy !== 1'b0; n++) @(posedge i_clk);
        hang(n);
    endtask

    initial
    begin
        repeat (8) @(posedge i_clk);
        i_reset <= 0;
        rd(`OFS_RSP_LO, d, r);
        chk(d, 32'h2000_0000);
        chk({o_servo_on, o_move_start, o_traj_busy}, 0);
        msg(8'hc0, `CODE_NOP);
        rd(`OFS_RSP_LO, d, r);
        chk(d, 32'h2100_00c0);
        i_ext_stop <= 1;
        repeat (3) @(posedge i_clk);
        chk(o_servo_on, 0);
        i_ext_stop <= 0;
        repeat (3) @(posedge i_clk);
        chk(o_servo_on, 1);
        msg(8'h40, `CODE_NOP);
        chk(o_servo_on, 0);
        $display("test servo done");
        base = n_mv;
        msg(8'hc1, `CODE_POS, 32'd300);
        chk(n_mv - base, 0);
        msg(8'hc0, `CODE_POS, 32'd300);
        msg(8'hc1, `CODE_POS, 32'd300);
        chk(n_mv - base, 1);
        chk(o_target_position, 32'd300);
        msg(8'hc0, `CODE_POS, 32'd300);
        chk(o_traj_busy, 1);
        wait_idle();
        msg(8'hc5, `CODE_POS, 32'd300);
        chk(o_target_position, CUR + 32'd300);
        wait_idle();
        $display("test position done");
        for (int k = 0; k < 5; k++)
        begin
            base = n_mv;
            msg(8'hc8, codes[k], 32'd1);
            msg(8'hc9, codes[k], 32'd1);
            chk(n_mv - base, 1);
            chk(32'(last_kind), k);
            wait_idle();
        end
        chk({o_direction, o_cont_speed}, {1'b1, 32'd1});
        chk(o_return_type, 8'h01);
        chk(o_target_position, ENDP);
        base = n_mv;
        msg(8'hc0, `CODE_SPEED, 32'h55);
        msg(8'hc1, `CODE_SPEED, 32'h55);
        chk(n_mv - base, 0);
        chk(o_target_speed, 32'h55);
        msg(8'hc0, `CODE_ACCEL, 32'h66);
        msg(8'hc0, `CODE_DECEL, 32'h77);
        chk({o_accel, o_decel}, {32'h66, 32'h77});
        $display("test codes done");
        msg(8'h80, `CODE_NOP);
        msg(8'h90, `CODE_NOP);
        msg(8'ha0, `CODE_NOP);
        msg(8'h80, `CODE_NOP);
        chk({n_sm, n_hd}, {32'd1, 32'd1});
        msg(8'hc1, `CODE_POS, 32'd9, 3'h2);
        rd(`OFS_RSP_LO, d, r);
        chk(d & 32'h0080_0040, 32'h0080_0040);
        msg(8'h80, `CODE_NOP);
        rd(`OFS_RSP_LO, d, r);
        chk(d & 32'h0080_0040, 0);
        msg(8'hc1, 5'h05, 32'd9);
        rd(`OFS_RSP_LO, d, r);
        chk(d[23], 1);
        chk(n_mv - base, 0);
        msg(8'h80, `CODE_NOP);
        $display("test errors done");
        msg(8'hc2, `CODE_NOP, 0, 3'h1, 8'h07);
        chk({n_bs, 24'h0, o_block_number}, {32'd1, 32'h7});
        msg(8'hc0, `CODE_NOP);
        chk(n_be, 1);
        for (int k = 0; k < 6; k++)
        begin
            msg(8'hc0, `CODE_NOP, 0, 3'h1, 0, rcodes[k]);
            rd(`OFS_RSP_HI, d, r);
            chk(d, rexp[k]);
        end
        msg(8'h80, `CODE_NOP, 0, 3'h1, 0, `RSP_CUR_POS);
        rd(`OFS_RSP_HI, d, r);
        chk(d, 32'h0);
        wr(`OFS_RSP_LO, 32'h0, r);
        chk(r, `RESP_SLVERR);
        rd(8'h10, d, r);
        chk({d, r}, {32'h0, `RESP_SLVERR});
        wr(`OFS_CMD_HI, 32'h1111_1111, r);
        wr(`OFS_CMD_HI, 32'h2222_2222, r, 4'h2);
        rd(`OFS_CMD_HI, d, r);
        chk(d, 32'h1111_2211);
        $display("test block and response done");
        test_done();
    end
endmodule
